// >>> sim/rfrxm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rfrxm_asserts
    import rfrxm_pkg::*;
(
    // watched ports
    input wire logic       i_ref_clk,
    input wire logic       i_rstn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_cmd_wr,
    input wire logic [3:0] i_cmd_code,
    input wire logic       i_rx_start,
    input wire logic       i_stream_end,
    input wire logic [3:0] i_stream_bits,
    input wire logic       i_crc_ok,
    input wire logic       o_crc_fail,
    input wire logic [7:0] i_err_flags,
    input wire logic       o_rx_active,
    input wire logic       o_rx_done,
    input wire logic       o_crc_check,
    input wire logic [2:0] o_rate,
    input wire logic       o_frame_b,
    input wire logic       o_err_push,
    input wire logic [7:0] o_err_byte
);
    logic [7:0] mode_ff;
    logic       wr_mode;
    logic       ok_len;
    // short streams only count as frames when short-ignore is off
    assign wr_mode = i_wr && i_addr == RFRXM_ADDR_MODE;
    assign ok_len  = i_stream_bits >= RFRXM_MIN_BITS || !mode_ff[RFRXM_SHORT_BIT];
    // shadow of the mode register, from software writes only
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_ff <= RFRXM_MODE_RESET;
        end else if (wr_mode) begin
            mode_ff <= i_wdata;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    a_mode_read: assert property (i_rd && i_addr == RFRXM_ADDR_MODE |=> o_rdata == mode_ff)
        else $error("mode readback wrong");
    a_field_out: assert property ((!wr_mode)[*2] |-> o_rate == mode_ff[6:4]
        && o_frame_b == (mode_ff[1:0] == RFRXM_FRM_B)) else $error("rate or framing wrong");
    a_start_arms: assert property (i_rx_start && !o_rx_active |-> ##2 o_rx_active)
        else $error("receiver not armed");
    a_single_end: assert property (o_rx_active && i_stream_end && !mode_ff[2] && ok_len
        |-> ##2 o_rx_done ##[0:1] !o_rx_active) else $error("single frame not ended");
    a_multi_push: assert property (o_rx_active && i_stream_end && mode_ff[2] && ok_len
        |-> ##2 o_err_push && o_err_byte == $past(i_err_flags, 2) && o_rx_active && !o_rx_done)
        else $error("error byte missing");
    a_short_drop: assert property (o_rx_active && i_stream_end && !ok_len
        |=> (o_rx_active && !o_rx_done && !o_err_push)[*3]) else $error("short stream kept");
    a_cmd_stop: assert property (o_rx_active && mode_ff[2] && i_cmd_wr
        && i_cmd_code != RFRXM_CMD_RECEIVE |-> ##2 o_rx_done)
        else $error("command did not stop");
    a_bit_stop: assert property (o_rx_active && wr_mode && mode_ff[2] && !i_wdata[2]
        |-> ##2 o_rx_done) else $error("clearing multi did not stop");
    a_crc_on: assert property ((o_rx_active && mode_ff[7])[*3] |-> o_crc_check)
        else $error("crc check off");
    a_crc_fail: assert property (mode_ff[7] && i_stream_end && !i_crc_ok
        |-> ##2 o_crc_fail) else $error("crc failure not reported");
    c_push: cover property (o_err_push);
    c_fail: cover property (o_crc_fail);
    c_done: cover property (o_rx_done);
    c_crc: cover property (o_crc_check);
endmodule
bind rfrxm_top rfrxm_asserts i_chk (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_cmd_wr, .i_cmd_code, .i_rx_start, .i_stream_end, .i_stream_bits, .i_err_flags,
    .o_rx_active, .o_rx_done, .o_crc_check, .o_rate, .o_frame_b, .o_err_push, .o_err_byte,
    .i_crc_ok, .o_crc_fail);
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rfrxm_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cw = 1'b0, st = 1'b0, se = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, ef = 8'h00, rdata, eb, m;
    logic [3:0] code = 4'h0, bits = 4'h0;
    logic [2:0] rate;
    logic       act, done, cchk, fb, push, cf, cok = 1'b1;
    int         num_errors = 0, checked = 0;
    rfrxm_top i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_cmd_wr(cw), .i_cmd_code(code), .i_rx_start(st),
        .i_stream_end(se), .i_stream_bits(bits), .i_crc_ok(cok), .i_err_flags(ef),
        .o_rx_active(act), .o_rx_done(done), .o_crc_check(cchk), .o_crc_fail(cf),
        .o_rate(rate), .o_frame_b(fb), .o_err_push(push), .o_err_byte(eb));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one-cycle strobe {wr, rd, cmd, start, end}, raised at the caller's edge
    // together with its qualifiers; returns at the taking edge
    task automatic cyc(input logic [4:0] s);
        {wr, rd, cw, st, se} <= s;
        @(posedge clk);
        {wr, rd, cw, st, se} <= 5'h00;
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] d);
        @(posedge clk);
        addr <= RFRXM_ADDR_MODE;
        wd <= d;
        cyc(5'h10);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        cyc(5'h08);
        #1 chk(rdata, e);
    endtask
    // start then look two cycles on
    task automatic arm;
        @(posedge clk);
        cyc(5'h02);
        gap(1);
        chk({7'h00, act}, 8'h01);
    endtask
    task automatic strm(input logic [3:0] b, input logic [7:0] f, input logic c);
        @(posedge clk);
        bits <= b;
        ef <= f;
        cok <= c;
        cyc(5'h01);
        gap(1);
    endtask
    // reset value, unmapped place, every rate and framing code
    task automatic t_regs;
        rreg(RFRXM_ADDR_MODE, RFRXM_MODE_RESET);
        rreg(8'h20, 8'h00);
        for (int i = 0; i < 8; i++) begin
            m = {2'h2, i[2:1], 2'h0, {2{i[0]}}};
            wreg(m);
            rreg(RFRXM_ADDR_MODE, m);
            gap(1);
            chk({5'h00, rate}, {5'h00, m[6:4]});
            chk({7'h00, fb}, {7'h00, m[0]});
        end
    endtask
    // single frame at 106 without crc ends reception
    task automatic t_single;
        wreg(8'h00);
        arm;
        chk({7'h00, cchk}, 8'h00);
        strm(4'h8, 8'h00, 1'b0);
        chk({6'h00, done, push}, 8'h02);
        gap(1);
        chk({6'h00, done, act}, 8'h00);
        chk({7'h00, cf}, 8'h00);
    endtask
    // a 3-bit stream is dropped, a 4-bit one is a frame
    task automatic t_short;
        wreg(8'h08);
        arm;
        strm(4'h3, 8'h00, 1'b1);
        chk({6'h00, done, act}, 8'h01);
        strm(4'h4, 8'h00, 1'b1);
        chk({7'h00, done}, 8'h01);
        gap(2);
    endtask
    // multi-frame: error bytes, receive command keeps it, other command or bit clear stops it
    task automatic t_multi;
        wreg(8'h94);
        arm;
        gap(1);
        chk({7'h00, cchk}, 8'h01);
        for (int i = 0; i < 2; i++) begin
            strm(4'h8, i ? 8'ha5 : 8'h5a, i == 0);
            chk({5'h00, push, act, done}, 8'h06);
            chk(eb, ef);
            chk({7'h00, cf}, i ? 8'h01 : 8'h00);
        end
        @(posedge clk);
        code <= RFRXM_CMD_RECEIVE;
        cyc(5'h04);
        gap(3);
        chk({6'h00, done, act}, 8'h01);
        @(posedge clk);
        code <= 4'h0;
        cyc(5'h04);
        gap(1);
        chk({7'h00, done}, 8'h01);
        rreg(RFRXM_ADDR_STATUS, 8'h04);
        gap(2);
        arm;
        chk({7'h00, cf}, 8'h00);
        wreg(8'h90);
        gap(1);
        chk({7'h00, done}, 8'h01);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_single;
        t_short;
        t_multi;
        close_out;
    end
    // hang guard, far beyond the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out;
    end
endmodule
`default_nettype wire

// >>> verilog/rfrxm_frame_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module rfrxm_frame_ctl
    import rfrxm_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // configuration
    input  wire rfrxm_mode_t i_mode,
    // receive events
    input  wire logic        i_rx_start,
    input  wire logic        i_stream_end,
    input  wire logic [3:0]  i_stream_bits,
    input  wire logic        i_stop_multi,
    input  wire logic [7:0]  i_err_flags,
    // results
    output logic             o_rx_active,
    output logic             o_rx_done,
    output logic             o_err_push,
    output logic [7:0]       o_err_byte
);
    rfrxm_state_t state_ff;
    rfrxm_state_t nxt_state;
    logic         short_stream;

    assign short_stream = i_stream_bits < RFRXM_MIN_BITS;

    // receiver sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RFRXM_IDLE: begin
                if (i_rx_start) begin
                    nxt_state = RFRXM_RECV;
                end
            end
            RFRXM_RECV: begin
                if (i_stop_multi && i_mode.multi) begin
                    nxt_state = RFRXM_IDLE;
                end else if (i_stream_end) begin
                    if (short_stream && i_mode.short_ign) begin
                        nxt_state = RFRXM_RECV;
                    end else if (i_mode.multi) begin
                        nxt_state = RFRXM_ERRB;
                    end else begin
                        nxt_state = RFRXM_IDLE;
                    end
                end
            end
            RFRXM_ERRB: begin
                nxt_state = i_stop_multi ? RFRXM_IDLE : RFRXM_RECV;
            end
            default: begin
                nxt_state = RFRXM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= RFRXM_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_active <= 1'b0;
            o_rx_done   <= 1'b0;
            o_err_push  <= 1'b0;
            o_err_byte  <= 8'h00;
        end else begin
            o_rx_active <= nxt_state != RFRXM_IDLE;
            o_rx_done   <= (state_ff != RFRXM_IDLE) && (nxt_state == RFRXM_IDLE);
            o_err_push  <= nxt_state == RFRXM_ERRB;
            if (nxt_state == RFRXM_ERRB) begin
                o_err_byte <= i_err_flags; // copy of error flags
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/rfrxm_pkg.sv
package rfrxm_pkg;
    // register map
    localparam logic [7:0] RFRXM_ADDR_MODE   = 8'h13;
    localparam logic [7:0] RFRXM_ADDR_STATUS = 8'h3f;
    localparam logic [7:0] RFRXM_MODE_RESET  = 8'h00;
    // field positions
    localparam int RFRXM_CRC_BIT   = 7;
    localparam int RFRXM_RATE_HI   = 6;
    localparam int RFRXM_RATE_LO   = 4;
    localparam int RFRXM_SHORT_BIT = 3;
    localparam int RFRXM_MULTI_BIT = 2;
    localparam int RFRXM_FRM_HI    = 1;
    localparam int RFRXM_FRM_LO    = 0;
    // rate and framing codes
    localparam logic [2:0] RFRXM_RATE_106 = 3'h0;
    localparam logic [2:0] RFRXM_RATE_212 = 3'h1;
    localparam logic [2:0] RFRXM_RATE_424 = 3'h2;
    localparam logic [2:0] RFRXM_RATE_848 = 3'h3;
    localparam logic [1:0] RFRXM_FRM_A    = 2'h0;
    localparam logic [1:0] RFRXM_FRM_B    = 2'h3;
    // shortest valid stream in bits
    localparam logic [3:0] RFRXM_MIN_BITS = 4'h4;
    // command code of the receive command
    localparam logic [3:0] RFRXM_CMD_RECEIVE = 4'h8;

    typedef struct packed {
        logic       crc_en;
        logic [2:0] rate;
        logic       short_ign;
        logic       multi;
        logic [1:0] framing;
    } rfrxm_mode_t;

    typedef enum logic [1:0] {
        RFRXM_IDLE = 2'b00,
        RFRXM_RECV = 2'b01,
        RFRXM_ERRB = 2'b11
    } rfrxm_state_t;
endpackage

// >>> verilog/rfrxm_top.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rfrxm_top
    import rfrxm_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // command register writes
    input  wire logic       i_cmd_wr,
    input  wire logic [3:0] i_cmd_code,
    // receiver events
    input  wire logic       i_rx_start,
    input  wire logic       i_stream_end,
    input  wire logic [3:0] i_stream_bits,
    input  wire logic       i_crc_ok,
    input  wire logic [7:0] i_err_flags,
    // to receiver and fifo
    output logic            o_rx_active,
    output logic            o_rx_done,
    output logic            o_crc_check,
    output logic            o_crc_fail,
    output logic [2:0]      o_rate,
    output logic            o_frame_b,
    output logic            o_err_push,
    output logic [7:0]      o_err_byte
);
    logic        rst_s1_ff;
    logic        rst_s2_ff;
    logic        rstn;
    rfrxm_mode_t mode_ff;
    logic        stop_multi;
    logic        fr_active;
    logic        fr_done;
    logic        fr_push;
    logic [7:0]  fr_byte;
    logic        crc_fail_ff;

    // one decode for every use of the mode register address
    function automatic logic is_mode_addr(input logic [7:0] addr);
        return addr == RFRXM_ADDR_MODE;
    endfunction

    // reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rstn = rst_s2_ff;

    // mode register write
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= RFRXM_MODE_RESET;
        end else if (i_wr && is_mode_addr(i_addr)) begin
            mode_ff <= i_wdata;
        end
    end

    // ends multi-frame: non-receive command, or bit cleared by software
    assign stop_multi = (i_cmd_wr && i_cmd_code != RFRXM_CMD_RECEIVE)
                      || (i_wr && is_mode_addr(i_addr)
                          && !i_wdata[RFRXM_MULTI_BIT]);

    rfrxm_frame_ctl u_frame_ctl (
        .i_ref_clk     (i_ref_clk),
        .i_rstn        (rstn),
        .i_mode        (mode_ff),
        .i_rx_start    (i_rx_start),
        .i_stream_end  (i_stream_end),
        .i_stream_bits (i_stream_bits),
        .i_stop_multi  (stop_multi),
        .i_err_flags   (i_err_flags),
        .o_rx_active   (fr_active),
        .o_rx_done     (fr_done),
        .o_err_push    (fr_push),
        .o_err_byte    (fr_byte)
    );

    // crc check result, sticky until next start
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            crc_fail_ff <= 1'b0;
        end else if (mode_ff.crc_en && i_stream_end && !i_crc_ok) begin
            crc_fail_ff <= 1'b1; // set wins over start
        end else if (i_rx_start) begin
            crc_fail_ff <= 1'b0;
        end
    end

    // registered outputs, one flop from source
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            o_rx_active <= 1'b0;
            o_rx_done   <= 1'b0;
            o_crc_check <= 1'b0;
            o_crc_fail  <= 1'b0;
            o_rate      <= RFRXM_RATE_106;
            o_frame_b   <= 1'b0;
            o_err_push  <= 1'b0;
            o_err_byte  <= 8'h00;
        end else begin
            o_rx_active <= fr_active;
            o_rx_done   <= fr_done;
            o_crc_check <= mode_ff.crc_en && fr_active;
            o_crc_fail  <= crc_fail_ff;
            o_rate      <= mode_ff.rate; // reserved codes passed as is
            o_frame_b   <= mode_ff.framing == RFRXM_FRM_B;
            o_err_push  <= fr_push;
            o_err_byte  <= fr_byte;
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (is_mode_addr(i_addr)) begin
                o_rdata <= mode_ff;
            end else if (i_addr == RFRXM_ADDR_STATUS) begin
                o_rdata <= {5'h00, crc_fail_ff, fr_push, fr_active};
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire
